// ### logic/pdw_top.sv
// target-side decoder from the memory and i/o windows onto two dsp cores
//
// What this block does
// - unpacked window: core zero data blocks 0-3 in consecutive 64 KB regions.
// - unpacked: core zero program RAM 64 KB, program ROM 16 KB, then reserved.
// - unpacked: core one data 0-1, gap, program RAM, program ROM, reserved.
// - packed window: core zero data blocks in 32 KB regions, two words per dword.
// - packed: program RAM 32 KB, ROM 8 KB, halves carry bits 23:8.
// - packed: core one from upper half, data, gap, program RAM, ROM, reserved.
// - each next aligned dword addresses the next location or location pair.
// - i/o window reaches control registers and memories through four registers.
// - indirect memory addresses in the lower range decode to core zero.
// - indirect memory addresses in the second range decode to core one.
// - indirect memory transfers are whole words only, 24 or 16 bits.
// - offset 0 holds register address and direction, resets to zero.
// - offset 4 carries register data moved either way, resets to zero.
// - offset 8 holds memory address and direction, resets to zero.
// - offset 12 carries memory data moved either way, resets to zero.
// - unpacked: top lane unused, 24-bit on lanes 2:0, 16-bit on 2:1.
// - packed: one word on lanes 1:0, the next on lanes 3:2.
// - packed access to 24-bit blocks moves bits 23:8, ignores low 8.
`timescale 1ns/1ps
`default_nettype none
`include "pdw_defs.svh"
module pdw_top
   import pdw_pkg::*;
#(
   parameter int IDX_W  = `PDW_IDX_W,
   parameter int REG_AW = 16
)(
   // clock, reset, enable
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   input  wire logic                   clk_en,
   // host target request
   input  wire logic                   pci_req,
   input  wire pdw_space_t             pci_space,
   input  wire logic [`PDW_OFF_W-1:0]  pci_offset,
   input  wire logic                   pci_we,
   input  wire logic [3:0]             pci_be,
   input  wire logic [31:0]            pci_wdata,
   // host target answer
   output var  logic                   pci_busy_r,
   output var  logic                   pci_done_r,
   output var  logic [31:0]            pci_rdata_r,
   // dsp memory port
   output var  logic                   mem_req_r,
   output var  logic                   mem_we_r,
   output var  logic                   mem_core_r,
   output var  pdw_kind_t              mem_kind_r,
   output var  logic [1:0]             mem_blk_r,
   output var  logic [IDX_W-1:0]       mem_index_r,
   output var  logic [23:0]            mem_wdata_r,
   output var  logic                   mem_keep_lo_r,
   input  wire logic                   mem_ack,
   input  wire logic [23:0]            mem_rdata,
   // control register port
   output var  logic                   reg_req_r,
   output var  logic                   reg_we_r,
   output var  logic [REG_AW-1:0]      reg_addr_r,
   output var  logic [31:0]            reg_wdata_r,
   input  wire logic                   reg_ack,
   input  wire logic [31:0]            reg_rdata
);
   // ==========================================================
   // parameter checks
   // ==========================================================
   if (IDX_W != `PDW_IDX_W) begin : g_idx_chk
      $error("pdw_top: IDX_W must match the decoder index width");
   end
   if (REG_AW < 1 || REG_AW > `PDW_DIR_BIT) begin : g_raw_chk
      $error("pdw_top: REG_AW must leave the direction bit free");
   end

   // ==========================================================
   // state
   // ==========================================================
   pdw_state_t                state_r, state_nxt;
   logic                      half_r, half_nxt;
   logic                      done_nxt, busy_nxt, mreq_nxt, rreq_nxt;
   logic [31:0]               rdata_nxt;
   pdw_space_t                op_space_r;
   logic [`PDW_OFF_W-1:0]     op_off_r;
   logic                      op_we_r;
   logic [3:0]                op_be_r;
   logic [31:0]               op_wdata_r;
   logic [31:0]               ind_raddr_r, ind_raddr_nxt;
   logic [31:0]               ind_rdat_r, ind_rdat_nxt;
   logic [31:0]               ind_maddr_r, ind_maddr_nxt;
   logic [31:0]               ind_mdat_r, ind_mdat_nxt;

   pdw_dec_if dec ();
   pdw_decode u_dec (.dec(dec));

   // ==========================================================
   // decode and lane steering
   // ==========================================================
   logic [31:0] be_mask;
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign be_mask[8*i +: 8] = {8{op_be_r[i]}};
   end

   wire        is_io    = (op_space_r == PDW_SP_IO);
   wire        is_pk    = (op_space_r == PDW_SP_PK);
   wire [3:0]  io_off   = op_off_r[3:0];
   wire        io_mdat  = is_io & (io_off == `PDW_IO_MDATA);
   wire        io_rdat  = is_io & (io_off == `PDW_IO_RDATA);
   wire        mdir_wr  = ind_maddr_r[`PDW_DIR_BIT];
   wire        rdir_wr  = ind_raddr_r[`PDW_DIR_BIT];
   wire        be_full  = (op_be_r == `PDW_BE_FULL);
   wire        is_prog  = (dec.kind != PDW_K_DATA);
   // in the mem state an issue is always the second half of a pair
   wire        hsel     = (state_r == PDW_ST_MEM);
   wire [15:0] half_w   = hsel ? op_wdata_r[31:16] : op_wdata_r[15:0];
   wire [15:0] half_rd  = is_prog ? mem_rdata[23:8] : mem_rdata[15:0];
   wire [31:0] merged   = (op_wdata_r & be_mask);

   // indirect memory address is a word address; x4 gives the unpacked offset
   assign dec.packed_sel = is_pk;
   assign dec.offset     = is_io ? {ind_maddr_r[`PDW_MADDR_MSB:0], 2'b00} : op_off_r;

   wire [23:0] wd_io  = is_prog ? op_wdata_r[23:0] : {8'h00, op_wdata_r[15:0]};
   wire [23:0] wd_pk  = is_prog ? {half_w, 8'h00} : {8'h00, half_w};
   wire [23:0] wd_unp = is_prog ? op_wdata_r[23:0] : {8'h00, op_wdata_r[23:8]};
   wire [23:0] wd_mem = is_io ? wd_io : (is_pk ? wd_pk : wd_unp);
   // partial lanes turn a window write into a harmless dummy read
   wire        lanes_ok = is_io | (is_pk ? (hsel ? &op_be_r[3:2] : &op_be_r[1:0])
                                         : (is_prog ? &op_be_r[2:0] : &op_be_r[2:1]));

   wire [31:0] rd_pk  = half_r ? {half_rd, pci_rdata_r[15:0]} : {16'h0000, half_rd};
   wire [31:0] rd_unp = is_prog ? {8'h00, mem_rdata}
                                : {8'h00, mem_rdata[15:0], 8'h00};
   wire [31:0] rd_lane = is_pk ? rd_pk : rd_unp;
   wire [31:0] io_mval = is_prog ? {8'h00, mem_rdata} : {16'h0000, mem_rdata[15:0]};

   wire [31:0] io_rd = (io_off == `PDW_IO_RADDR) ? ind_raddr_r :
                       (io_off == `PDW_IO_RDATA) ? ind_rdat_r  :
                       (io_off == `PDW_IO_MADDR) ? ind_maddr_r :
                       (io_off == `PDW_IO_MDATA) ? ind_mdat_r  : `PDW_RST_WORD;

   // memory transfer: window hit, or data register in matching direction
   wire io_mem_go = io_mdat & dec.hit
                  & (op_we_r ? (be_full & mdir_wr) : ~mdir_wr);
   wire mem_go    = (~is_io & dec.hit) | io_mem_go;
   wire io_reg_go = io_rdat & (op_we_r ? rdir_wr : ~rdir_wr);
   // an unmapped indirect read answers zero, like a reserved window hole
   wire [31:0] dec_val = ~is_io ? `PDW_RST_WORD :
                         (io_mdat & ~op_we_r & ~mdir_wr) ? `PDW_RST_WORD : io_rd;

   // ==========================================================
   // sequencer
   // ==========================================================
   always_comb begin
      state_nxt     = state_r;
      half_nxt      = half_r;
      done_nxt      = 1'b0;
      busy_nxt      = pci_busy_r;
      mreq_nxt      = 1'b0;
      rreq_nxt      = 1'b0;
      rdata_nxt     = pci_rdata_r;
      ind_raddr_nxt = ind_raddr_r;
      ind_rdat_nxt  = ind_rdat_r;
      ind_maddr_nxt = ind_maddr_r;
      ind_mdat_nxt  = ind_mdat_r;
      case (state_r)
         PDW_ST_IDLE: begin
            if (pci_req) begin
               state_nxt = PDW_ST_DEC;
               busy_nxt  = 1'b1;
               rdata_nxt = `PDW_RST_WORD;
            end
         end
         PDW_ST_DEC: begin
            if (is_io & op_we_r) begin
               case (io_off)
                  `PDW_IO_RADDR: ind_raddr_nxt = (ind_raddr_r & ~be_mask) | merged;
                  `PDW_IO_RDATA: ind_rdat_nxt  = (ind_rdat_r & ~be_mask) | merged;
                  `PDW_IO_MADDR: ind_maddr_nxt = (ind_maddr_r & ~be_mask) | merged;
                  `PDW_IO_MDATA: begin
                     if (be_full) begin
                        ind_mdat_nxt = op_wdata_r;
                     end
                  end
                  default: ind_raddr_nxt = ind_raddr_r;
               endcase
            end
            if (mem_go) begin
               state_nxt = PDW_ST_MEM;
               mreq_nxt  = 1'b1;
               half_nxt  = 1'b0;
            end else if (io_reg_go) begin
               state_nxt = PDW_ST_REG;
               rreq_nxt  = 1'b1;
            end else begin
               state_nxt = PDW_ST_IDLE;
               done_nxt  = 1'b1;
               busy_nxt  = 1'b0;
               rdata_nxt = dec_val;
            end
         end
         PDW_ST_MEM: begin
            if (mem_ack) begin
               if (~op_we_r) begin
                  rdata_nxt = is_io ? io_mval : rd_lane;
               end
               if (is_io & ~op_we_r) begin
                  ind_mdat_nxt = io_mval;
               end
               if (is_pk & ~half_r) begin
                  mreq_nxt = 1'b1;
                  half_nxt = 1'b1;
               end else begin
                  state_nxt = PDW_ST_IDLE;
                  done_nxt  = 1'b1;
                  busy_nxt  = 1'b0;
               end
            end
         end
         PDW_ST_REG: begin
            if (reg_ack) begin
               if (~op_we_r) begin
                  ind_rdat_nxt = reg_rdata;
                  rdata_nxt    = reg_rdata;
               end
               state_nxt = PDW_ST_IDLE;
               done_nxt  = 1'b1;
               busy_nxt  = 1'b0;
            end
         end
         default: begin
            state_nxt = PDW_ST_IDLE;
            busy_nxt  = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // registers
   // ==========================================================
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r     <= PDW_ST_IDLE;
         half_r      <= 1'b0;
         pci_busy_r  <= 1'b0;
         pci_done_r  <= 1'b0;
         pci_rdata_r <= `PDW_RST_WORD;
         mem_req_r   <= 1'b0;
         reg_req_r   <= 1'b0;
      end else if (clk_en) begin
         state_r     <= state_nxt;
         half_r      <= half_nxt;
         pci_busy_r  <= busy_nxt;
         pci_done_r  <= done_nxt;
         pci_rdata_r <= rdata_nxt;
         mem_req_r   <= mreq_nxt;
         reg_req_r   <= rreq_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ind_raddr_r <= `PDW_RST_WORD;
         ind_rdat_r  <= `PDW_RST_WORD;
         ind_maddr_r <= `PDW_RST_WORD;
         ind_mdat_r  <= `PDW_RST_WORD;
      end else if (clk_en) begin
         ind_raddr_r <= ind_raddr_nxt;
         ind_rdat_r  <= ind_rdat_nxt;
         ind_maddr_r <= ind_maddr_nxt;
         ind_mdat_r  <= ind_mdat_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         op_space_r <= PDW_SP_UNP;
         op_off_r   <= '0;
         op_we_r    <= 1'b0;
         op_be_r    <= 4'h0;
         op_wdata_r <= `PDW_RST_WORD;
      end else if (clk_en && state_r == PDW_ST_IDLE && pci_req) begin
         op_space_r <= pci_space;
         op_off_r   <= pci_offset;
         op_we_r    <= pci_we;
         op_be_r    <= pci_be;
         op_wdata_r <= pci_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mem_we_r      <= 1'b0;
         mem_core_r    <= 1'b0;
         mem_kind_r    <= PDW_K_DATA;
         mem_blk_r     <= 2'b00;
         mem_index_r   <= '0;
         mem_wdata_r   <= 24'h00_0000;
         mem_keep_lo_r <= 1'b0;
      end else if (clk_en && mreq_nxt) begin
         mem_we_r      <= op_we_r & lanes_ok;
         mem_core_r    <= dec.core;
         mem_kind_r    <= dec.kind;
         mem_blk_r     <= dec.blk;
         mem_index_r   <= {dec.index[IDX_W-1:1], dec.index[0] | hsel};
         mem_wdata_r   <= wd_mem;
         mem_keep_lo_r <= is_pk & is_prog;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_we_r    <= 1'b0;
         reg_addr_r  <= '0;
         reg_wdata_r <= `PDW_RST_WORD;
      end else if (clk_en && rreq_nxt) begin
         reg_we_r    <= op_we_r;
         reg_addr_r  <= ind_raddr_r[REG_AW-1:0];
         reg_wdata_r <= (ind_rdat_r & ~be_mask) | merged;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   resv_read_zero_a: assert property (
      (clk_en && state_r == PDW_ST_DEC && !is_io && !dec.hit)
      |=> (pci_done_r && pci_rdata_r == `PDW_RST_WORD && !mem_req_r))
      else $error("reserved window access did not answer zero");
   unp_data_map_a: assert property (
      (op_space_r == PDW_SP_UNP && dec.hit && dec.kind == PDW_K_DATA && !dec.core)
      |-> (dec.blk == op_off_r[17:16] && dec.index == op_off_r[15:2]))
      else $error("unpacked data block mapping wrong");
   unp_gap_miss_a: assert property (
      (op_space_r == PDW_SP_UNP && op_off_r >= `PDW_RESV_LO && op_off_r <= `PDW_RESV_HI)
      |-> !dec.hit)
      else $error("unpacked gap decoded as mapped");
   pk_index_map_a: assert property (
      (is_pk && dec.hit) |-> (dec.index == {op_off_r[14:2], 1'b0} && dec.core == op_off_r[18]))
      else $error("packed index mapping wrong");
   pk_second_half_a: assert property (
      (clk_en && state_r == PDW_ST_MEM && mem_ack && is_pk && !half_r)
      |=> (mem_req_r && mem_index_r[0] && mem_index_r[IDX_W-1:1] == $past(mem_index_r[IDX_W-1:1])))
      else $error("packed pair second location not issued");
   keep_low_a: assert property (
      mem_req_r |-> (mem_keep_lo_r == (is_pk && mem_kind_r != PDW_K_DATA)))
      else $error("low byte protection wrong");
   whole_word_a: assert property (
      (clk_en && state_r == PDW_ST_DEC && io_mdat && op_we_r && !be_full)
      |=> (!mem_req_r && pci_done_r && ind_mdat_r == $past(ind_mdat_r)))
      else $error("partial indirect memory write not ignored");
   ind_read_go_a: assert property (
      (clk_en && state_r == PDW_ST_MEM && mem_ack && io_mdat && !op_we_r)
      |=> (pci_done_r && ind_mdat_r == pci_rdata_r))
      else $error("indirect memory read did not complete");
   ind_core_a: assert property (
      (is_io && dec.hit) |-> (dec.core == ind_maddr_r[`PDW_MADDR_MSB]))
      else $error("indirect core select wrong");
   done_pulse_a: assert property (
      (clk_en && pci_done_r) |=> (!pci_done_r && pci_busy_r == $past(pci_req)))
      else $error("done held longer than one cycle");

   pk_read_c:   cover property (pci_done_r && is_pk && !op_we_r);
   ind_write_c: cover property (mem_req_r && mem_we_r && is_io);
   resv_read_c: cover property (state_r == PDW_ST_DEC && !is_io && !dec.hit);
   reg_read_c:  cover property (reg_req_r && !reg_we_r);
endmodule // pdw_top
`default_nettype wire

// ### logic/pdw_defs.svh
// offsets, field positions, reset values and encodings for the window decoder
`ifndef PDW_DEFS_SVH
`define PDW_DEFS_SVH
`define PDW_OFF_W      20
`define PDW_IDX_W      14
`define PDW_IO_RADDR   4'h0
`define PDW_IO_RDATA   4'h4
`define PDW_IO_MADDR   4'h8
`define PDW_IO_MDATA   4'hC
`define PDW_DIR_BIT    31
`define PDW_MADDR_MSB  17
`define PDW_CORE_BIT   19
`define PDW_PK_TOP_BIT 19
`define PDW_RGN_MSB    18
`define PDW_RGN_LSB    16
`define PDW_BLK_MSB    17
`define PDW_IDX_MSB    15
`define PDW_IDX_LSB    2
`define PDW_ROM_MSB    15
`define PDW_ROM_LSB    14
`define PDW_RGN_PRAM   3'h4
`define PDW_RGN_PROM   3'h5
`define PDW_RST_WORD   32'h0000_0000
`define PDW_BE_FULL    4'hF
`define PDW_RESV_LO    20'h5_4000
`define PDW_RESV_HI    20'h7_FFFC
`endif

// ### logic/pdw_pkg.sv
// types shared by the window decoder files
`default_nettype none
package pdw_pkg;
   typedef enum logic [2:0] {
      PDW_ST_IDLE = 3'b000,
      PDW_ST_DEC  = 3'b001,
      PDW_ST_MEM  = 3'b010,
      PDW_ST_REG  = 3'b011
   } pdw_state_t;
   typedef enum logic [1:0] {
      PDW_K_DATA = 2'b00,
      PDW_K_PRAM = 2'b01,
      PDW_K_PROM = 2'b10
   } pdw_kind_t;
   typedef enum logic [1:0] {
      PDW_SP_UNP = 2'b00,
      PDW_SP_PK  = 2'b01,
      PDW_SP_IO  = 2'b10
   } pdw_space_t;
endpackage
`default_nettype wire

// ### logic/pdw_dec_if.sv
// carrier between the sequencer and the address decoder
`timescale 1ns/1ps
`default_nettype none
`include "pdw_defs.svh"
interface pdw_dec_if;
   import pdw_pkg::*;
   logic                    packed_sel;
   logic [`PDW_OFF_W-1:0]   offset;
   logic                    hit;
   logic                    core;
   pdw_kind_t               kind;
   logic [1:0]              blk;
   logic [`PDW_IDX_W-1:0]   index;
   modport requester (output packed_sel, offset, input hit, core, kind, blk, index);
   modport decoder   (input packed_sel, offset, output hit, core, kind, blk, index);
endinterface // pdw_dec_if
`default_nettype wire

// ### logic/pdw_decode.sv
// combinational decode of a window offset into core, block and word index
`timescale 1ns/1ps
`default_nettype none
`include "pdw_defs.svh"
module pdw_decode
   import pdw_pkg::*;
(
   // decode request and result
   pdw_dec_if.decoder dec
);
   // ==========================================================
   // normalise packed offsets onto the unpacked layout
   // ==========================================================
   // a packed region is half the size of its unpacked twin, so one
   // left shift lines both windows up and one decoder serves both
   logic [`PDW_OFF_W-1:0] norm;
   logic [2:0]            rgn;
   logic                  core_w;
   logic                  is_data;
   logic                  is_pram;
   logic                  is_prom;
   logic                  pk_over;

   assign norm    = dec.packed_sel ? {dec.offset[`PDW_OFF_W-2:0], 1'b0} : dec.offset;
   assign pk_over = dec.packed_sel & dec.offset[`PDW_PK_TOP_BIT];
   assign rgn     = norm[`PDW_RGN_MSB:`PDW_RGN_LSB];
   assign core_w  = norm[`PDW_CORE_BIT];
   // core zero owns four data blocks, core one two; the rest is a gap
   assign is_data = core_w ? (rgn[2:1] == 2'b00) : (rgn[2] == 1'b0);
   assign is_pram = (rgn == `PDW_RGN_PRAM);
   assign is_prom = (rgn == `PDW_RGN_PROM)
                  & (norm[`PDW_ROM_MSB:`PDW_ROM_LSB] == 2'b00);

   // ==========================================================
   // results
   // ==========================================================
   assign dec.hit   = ~pk_over & (is_data | is_pram | is_prom);
   assign dec.core  = core_w;
   assign dec.kind  = is_data ? PDW_K_DATA : (is_pram ? PDW_K_PRAM : PDW_K_PROM);
   assign dec.blk   = norm[`PDW_BLK_MSB:`PDW_RGN_LSB];
   assign dec.index = norm[`PDW_IDX_MSB:`PDW_IDX_LSB];
endmodule // pdw_decode
`default_nettype wire

// ### test/pdw_far_model.sv
// far-side model: memories of both cores and the control register file
`timescale 1ns/1ps
`default_nettype none
module pdw_far_model
   import pdw_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // memory side
   input  wire logic        mem_req_r,
   input  wire logic        mem_we_r,
   input  wire logic        mem_core_r,
   input  wire pdw_kind_t   mem_kind_r,
   input  wire logic [1:0]  mem_blk_r,
   input  wire logic [13:0] mem_index_r,
   input  wire logic [23:0] mem_wdata_r,
   input  wire logic        mem_keep_lo_r,
   output var  logic        mem_ack,
   output var  logic [23:0] mem_rdata,
   // control register side
   input  wire logic        reg_req_r,
   input  wire logic        reg_we_r,
   input  wire logic [15:0] reg_addr_r,
   input  wire logic [31:0] reg_wdata_r,
   output var  logic        reg_ack,
   output var  logic [31:0] reg_rdata
);
   logic [23:0] mem_q [logic [18:0]];
   logic [31:0] reg_q [logic [15:0]];
   logic [18:0] key;
   logic [23:0] old;
   assign key = {mem_core_r, mem_kind_r, mem_blk_r, mem_index_r};
   // data lines flip outside an answer so a stale value never looks valid
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         reg_ack <= 1'b0;
         mem_rdata <= 24'h5A_5A5A;
         reg_rdata <= 32'h5A5A_5A5A;
      end else begin
         mem_ack <= mem_req_r;
         reg_ack <= reg_req_r;
         old = mem_q.exists(key) ? mem_q[key] : 24'h00_0000;
         if (mem_req_r && mem_we_r) begin
            mem_q[key] = mem_keep_lo_r ? {mem_wdata_r[23:8], old[7:0]} : mem_wdata_r;
         end
         mem_rdata <= mem_req_r ? old : ~mem_rdata;
         if (reg_req_r && reg_we_r) begin
            reg_q[reg_addr_r] = reg_wdata_r;
         end
         reg_rdata <= !reg_req_r ? ~reg_rdata :
                      reg_q.exists(reg_addr_r) ? reg_q[reg_addr_r] : 32'h0000_0000;
      end
   end
endmodule // pdw_far_model
`default_nettype wire

// ### test/pdw_top_tb.sv
// self-checking bench for the window decoder
`timescale 1ns/1ps
`default_nettype none
module pdw_top_tb
   import pdw_pkg::*;
;
   logic ref_clk = 1'b0, nrst = 1'b0, pci_req = 1'b0, pci_we = 1'b0;
   pdw_space_t pci_space = PDW_SP_UNP;
   logic [19:0] pci_offset = 20'h0_0000;
   logic [3:0] pci_be = 4'hF, be_next = 4'hF;
   logic [31:0] pci_wdata = 32'h0000_0000;
   logic pci_busy_r, pci_done_r, mem_req_r, mem_we_r, mem_core_r, mem_keep_lo_r, mem_ack;
   logic reg_req_r, reg_we_r, reg_ack;
   pdw_kind_t mem_kind_r;
   logic [1:0] mem_blk_r;
   logic [13:0] mem_index_r;
   logic [23:0] mem_wdata_r, mem_rdata;
   logic [31:0] pci_rdata_r, reg_wdata_r, reg_rdata;
   logic [15:0] reg_addr_r;
   int bad_count = 0, checked = 0, cycles = 0;
   pdw_top dut (.ref_clk, .nrst, .clk_en(1'b1), .pci_req, .pci_space, .pci_offset, .pci_we,
      .pci_be, .pci_wdata, .pci_busy_r, .pci_done_r, .pci_rdata_r, .mem_req_r, .mem_we_r,
      .mem_core_r, .mem_kind_r, .mem_blk_r, .mem_index_r, .mem_wdata_r, .mem_keep_lo_r,
      .mem_ack, .mem_rdata, .reg_req_r, .reg_we_r, .reg_addr_r, .reg_wdata_r, .reg_ack,
      .reg_rdata);
   pdw_far_model far (.ref_clk, .nrst, .mem_req_r, .mem_we_r, .mem_core_r, .mem_kind_r,
      .mem_blk_r, .mem_index_r, .mem_wdata_r, .mem_keep_lo_r, .mem_ack, .mem_rdata,
      .reg_req_r, .reg_we_r, .reg_addr_r, .reg_wdata_r, .reg_ack, .reg_rdata);
   initial forever #10 ref_clk = ~ref_clk;
   task automatic test_done;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         test_done;
      end
   end
   // one request pulse, then wait for done under a bound
   task automatic op(input pdw_space_t s, input logic [19:0] o, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      logic hi;
      @(posedge ref_clk);
      pci_req <= 1'b1;
      pci_space <= s;
      pci_offset <= o;
      pci_we <= w;
      pci_be <= be_next;
      pci_wdata <= d;
      @(posedge ref_clk);
      pci_req <= 1'b0;
      r = 32'hDEAD_DEAD;
      for (n = 0; n < 40; n++) begin
         #1;
         if (n == 0) hi = pci_busy_r;
         if (pci_done_r === 1'b1) begin
            r = pci_rdata_r;
            break;
         end
         @(posedge ref_clk);
      end
      // busy seen just after the take, done reached and busy dropped with it
      checked++;
      if ({hi, pci_busy_r, pci_done_r} !== 3'b101) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, {hi, pci_busy_r, pci_done_r}, 3'h5);
      end
   endtask
   task automatic wr(input pdw_space_t s, input logic [19:0] o, input logic [31:0] d);
      logic [31:0] r;
      op(s, o, 1'b1, d, r);
   endtask
   task automatic rd(input pdw_space_t s, input logic [19:0] o, input logic [31:0] e);
      logic [31:0] r;
      op(s, o, 1'b0, 32'h0000_0000, r);
      checked++;
      if (r !== e) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, r, e);
      end
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 16; i += 4) rd(PDW_SP_IO, 20'(i), 32'h0000_0000);
      // top of data block 3 seen through both memory windows
      wr(PDW_SP_UNP, 20'h3_FFFC, 32'h0012_3400);
      rd(PDW_SP_PK, 20'h1_FFFC, 32'h1234_0000);
      wr(PDW_SP_UNP, 20'h4_0004, 32'h00AB_CDEF);
      wr(PDW_SP_PK, 20'h2_0000, 32'hBEEF_CAFE);
      rd(PDW_SP_UNP, 20'h4_0000, 32'h00CA_FE00);
      rd(PDW_SP_UNP, 20'h4_0004, 32'h00BE_EFEF);
      rd(PDW_SP_PK, 20'h2_0000, 32'hBEEF_CAFE);
      wr(PDW_SP_UNP, 20'h5_3FFC, 32'h0077_8899);
      rd(PDW_SP_PK, 20'h2_9FFC, 32'h7788_0000);
      // reserved space swallows writes and reads zero
      wr(PDW_SP_UNP, 20'h5_4000, 32'h00FF_FFFF);
      rd(PDW_SP_UNP, 20'h5_4000, 32'h0000_0000);
      rd(PDW_SP_PK, 20'h2_A000, 32'h0000_0000);
      rd(PDW_SP_UNP, 20'hA_0000, 32'h0000_0000);
      rd(PDW_SP_PK, 20'h5_0000, 32'h0000_0000);
      wr(PDW_SP_PK, 20'h4_0000, 32'h2222_1111);
      rd(PDW_SP_UNP, 20'h8_0004, 32'h0022_2200);
      wr(PDW_SP_UNP, 20'hD_0000, 32'h0013_5790);
      rd(PDW_SP_PK, 20'h6_8000, 32'h0000_1357);
      // indirect memory: address first, then data
      wr(PDW_SP_IO, 20'h0_0008, 32'h0000_FFFF);
      rd(PDW_SP_IO, 20'h0_000C, 32'h0000_1234);
      rd(PDW_SP_IO, 20'h0_0008, 32'h0000_FFFF);
      wr(PDW_SP_IO, 20'h0_0008, 32'h0001_0001);
      rd(PDW_SP_IO, 20'h0_000C, 32'h00BE_EFEF);
      wr(PDW_SP_IO, 20'h0_0008, 32'h8002_0000);
      wr(PDW_SP_IO, 20'h0_000C, 32'h0000_4321);
      rd(PDW_SP_UNP, 20'h8_0000, 32'h0043_2100);
      // a partial data register write must leave register and memory alone
      be_next = 4'h3;
      wr(PDW_SP_IO, 20'h0_000C, 32'h0000_7777);
      be_next = 4'hF;
      rd(PDW_SP_IO, 20'h0_000C, 32'h0000_4321);
      rd(PDW_SP_UNP, 20'h8_0000, 32'h0043_2100);
      // control register path: read direction store must not reach the register
      wr(PDW_SP_IO, 20'h0_0000, 32'h8000_0012);
      wr(PDW_SP_IO, 20'h0_0004, 32'hCAFE_F00D);
      wr(PDW_SP_IO, 20'h0_0000, 32'h0000_0012);
      wr(PDW_SP_IO, 20'h0_0004, 32'h1111_1111);
      rd(PDW_SP_IO, 20'h0_0004, 32'hCAFE_F00D);
      rd(PDW_SP_IO, 20'h0_0000, 32'h0000_0012);
      // second reset in mid-run: dirty indirect registers must read zero again
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 16; i += 4) rd(PDW_SP_IO, 20'(i), 32'h0000_0000);
      test_done;
   end
endmodule // pdw_top_tb
`default_nettype wire
